/* File: pefs_defs.vh */
/*
  constants for the port e low pin function select block:
  register offset, field positions, reset values, pin types.
  assumes inclusion by bare name from the block's design files.
*/
`ifndef PEFS_DEFS_VH
`define PEFS_DEFS_VH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define PEFS_CTRL_OFFSET   12'h000
`define PEFS_ADDR_W        12

// ----------------------------------------------------------------
// field positions of the function select bits
// ----------------------------------------------------------------
`define PEFS_PIN7_SEL_BIT  14
`define PEFS_PIN6_SEL_BIT  12
`define PEFS_PIN5_SEL_BIT  10
`define PEFS_PIN4_SEL_BIT  8
`define PEFS_PIN3_SEL_BIT  6
`define PEFS_PIN2_SEL_BIT  4
`define PEFS_PIN1_SEL_BIT  2
`define PEFS_PIN0_SEL_BIT  0

// ----------------------------------------------------------------
// writable bits and reset values
// ----------------------------------------------------------------
`define PEFS_CTRL_WMASK    16'h5555
`define PEFS_CTRL_RST_NORM 16'h0040
`define PEFS_CTRL_RST_HIF  16'h5555

// ----------------------------------------------------------------
// pins whose host function is an output of the device
// ----------------------------------------------------------------
`define PEFS_HIF_OUT_PINS  8'h16

// ----------------------------------------------------------------
// axi responses
// ----------------------------------------------------------------
`define PEFS_RESP_OKAY     2'b00
`define PEFS_RESP_SLVERR   2'b10

`endif

/* File: pefs_pin_cell.v */
/*
  one pin of the function select: routes a pad to the general port
  or to a host interface signal, all outputs registered.
  assumes pad input synchronous to aclk and a synchronous reset.
*/
`timescale 1ns/10ps

module pefs_pin_cell #(
  parameter HIF_IS_OUT = 0          // host function drives the pad
) (
  // clock and reset
  input  wire aclk,
  input  wire aresetn,
  // function select
  input  wire sel_host,
  // pad side
  input  wire pad_in,
  output reg  pad_out_q,
  output reg  pad_oe_q,
  // general port side
  input  wire gp_out,
  input  wire gp_oe,
  output reg  gp_in_q,
  // host interface side
  input  wire hif_out,
  output reg  hif_in_q
);

  // ----------------------------------------------------------------
  // next values of the pin outputs
  // ----------------------------------------------------------------
  reg pad_out_d;                     // value toward the pad
  reg pad_oe_d;                      // pad drive enable
  reg gp_in_d;                       // pad level seen by the port
  reg hif_in_d;                      // pad level seen by host logic

  // steer the pad by the select bit
  always @* begin
    pad_out_d = 1'b0;
    pad_oe_d  = 1'b0;
    gp_in_d   = 1'b0;
    hif_in_d  = 1'b0;
    if (!sel_host) begin
      // general port owns the pin
      pad_out_d = gp_out;
      pad_oe_d  = gp_oe;
      gp_in_d   = pad_in;
    end else if (HIF_IS_OUT != 0) begin
      // host output drives the pin
      pad_out_d = hif_out;
      pad_oe_d  = 1'b1;
    end else begin
      // host input listens to the pin
      hif_in_d  = pad_in;
    end
  end

  // register all outputs, released pad during reset
  always @(posedge aclk) begin
    if (!aresetn) begin
      pad_out_q <= 1'b0;
      pad_oe_q  <= 1'b0;
      gp_in_q   <= 1'b0;
      hif_in_q  <= 1'b0;
    end else begin
      pad_out_q <= pad_out_d;
      pad_oe_q  <= pad_oe_d;
      gp_in_q   <= gp_in_d;
      hif_in_q  <= hif_in_d;
    end
  end

endmodule

/* File: pefs_top.v */
/*
  port e low pin function select: one 16-bit control register on an
  axi4-lite slave, one function select bit per pin, eight pin cells.
  assumes a single clock, synchronous active-low reset, and a boot
  mode level that is stable while reset is asserted.

// Operation
// - bit14 routes pin7 to host register select
// - bit12 routes pin6 to host write strobe
// - bit10 routes pin5 to host read strobe
// - bit8 drives pin4 as host interrupt
// - bit6 routes pin3 to host mode, resets 1
// - bit4 drives pin2 as host dma request
// - bit2 drives pin1 as host ready
// - bit0 routes pin0 to host enable
// - odd bits read zero, written zero
*/
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "pefs_defs.vh"

module pefs_top (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // boot mode strap, high in host interface boot
  input  wire        hif_boot_mode,
  // axi4-lite write address
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // pads
  input  wire [7:0]  pad_in,
  output wire [7:0]  pad_out,
  output wire [7:0]  pad_oe,
  // general port
  input  wire [7:0]  gp_out,
  input  wire [7:0]  gp_oe,
  output wire [7:0]  gp_in,
  // host interface inputs, taken from the pads
  output wire        host_reg_select_in,
  output wire        host_write_strobe_in,
  output wire        host_read_strobe_in,
  output wire        host_mode_in,
  output wire        host_enable_in,
  // host interface outputs, driven onto the pads
  input  wire        host_interrupt_out,
  input  wire        host_dma_request_out,
  input  wire        host_ready_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg  [15:0] ctrl_q;                // port_e_low_function_control
  reg  [15:0] ctrl_d;
  // write side holding registers
  reg         aw_got_q;              // write address held
  reg         aw_got_d;
  reg         w_got_q;               // write data held
  reg         w_got_d;
  reg  [11:0] awaddr_q;              // held write address
  reg  [11:0] awaddr_d;
  reg  [31:0] wdata_q;               // held write data
  reg  [31:0] wdata_d;
  reg  [3:0]  wstrb_q;               // held byte enables
  reg  [3:0]  wstrb_d;
  // handshake outputs of the write channels
  reg         awready_q;
  reg         awready_d;
  reg         wready_q;
  reg         wready_d;
  reg         bvalid_q;
  reg         bvalid_d;
  reg  [1:0]  bresp_q;
  reg  [1:0]  bresp_d;
  // read side
  reg         arready_q;
  reg         arready_d;
  reg         rvalid_q;
  reg         rvalid_d;
  reg  [31:0] rdata_q;
  reg  [31:0] rdata_d;
  reg  [1:0]  rresp_q;
  reg  [1:0]  rresp_d;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  wire        aw_hit;                // held write address maps ctrl
  wire        ar_hit;                // read address maps ctrl
  wire [15:0] wr_bytes;              // write mask from byte enables
  wire [15:0] wr_mask;               // bits a write may change
  wire [7:0]  pin_sel;               // one select bit per pin
  wire [7:0]  hif_in;                // host-side inputs per pin
  wire [7:0]  hif_out;               // host-side outputs per pin

  // word compare ignores the byte lane bits
  assign aw_hit   = ({awaddr_q[11:2], 2'b00} == `PEFS_CTRL_OFFSET);
  assign ar_hit   = ({s_axi_araddr[11:2], 2'b00} == `PEFS_CTRL_OFFSET);
  // byte lanes 3 and 2 carry no register bits
  assign wr_bytes = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  // reserved odd bits never take a write
  assign wr_mask  = wr_bytes & `PEFS_CTRL_WMASK;

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  // take address and data in either order, answer after both
  // the commit waits one cycle after both halves are held, so the
  // stored word is settled by the time bvalid rises
  always @* begin
    ctrl_d    = ctrl_q;
    aw_got_d  = aw_got_q;
    w_got_d   = w_got_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    // address handshake
    if (s_axi_awvalid && awready_q) begin
      aw_got_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    // data handshake
    if (s_axi_wvalid && wready_q) begin
      w_got_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    // both held: commit and raise the response
    if (aw_got_q && w_got_q && !bvalid_q) begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bvalid_d = 1'b1;
      if (aw_hit) begin
        ctrl_d  = (ctrl_q & ~wr_mask) | (wdata_q[15:0] & wr_mask);
        bresp_d = `PEFS_RESP_OKAY;
      end else begin
        // unmapped word, nothing stored
        bresp_d = `PEFS_RESP_SLVERR;
      end
    end
    // response taken
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    // readiness for the next beat
    awready_d = !aw_got_d && !bvalid_d;
    wready_d  = !w_got_d && !bvalid_d;
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  // one read at a time, data one cycle after the address
  // arready falls with rvalid, so a second address waits until
  // the data beat has been taken
  always @* begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      if (ar_hit) begin
        // reserved bits and upper half read zero
        rdata_d = {16'h0000, ctrl_q & `PEFS_CTRL_WMASK};
        rresp_d = `PEFS_RESP_OKAY;
      end else begin
        rdata_d = 32'h00000000;
        rresp_d = `PEFS_RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    arready_d = !rvalid_d;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // reset loads the defaults picked by the boot strap
  // only the control word depends on the strap, the bus side
  // always leaves reset idle
  always @(posedge aclk) begin
    if (!aresetn) begin
      if (hif_boot_mode) begin
        ctrl_q <= `PEFS_CTRL_RST_HIF;
      end else begin
        ctrl_q <= `PEFS_CTRL_RST_NORM;
      end
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      awaddr_q  <= 12'h000;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `PEFS_RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= `PEFS_RESP_OKAY;
    end else begin
      ctrl_q    <= ctrl_d;
      aw_got_q  <= aw_got_d;
      w_got_q   <= w_got_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // bus outputs straight from flip-flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // ----------------------------------------------------------------
  // function select fields
  // ----------------------------------------------------------------
  // one select per pin
  assign pin_sel[7] = ctrl_q[`PEFS_PIN7_SEL_BIT];
  assign pin_sel[6] = ctrl_q[`PEFS_PIN6_SEL_BIT];
  assign pin_sel[5] = ctrl_q[`PEFS_PIN5_SEL_BIT];
  assign pin_sel[4] = ctrl_q[`PEFS_PIN4_SEL_BIT];
  assign pin_sel[3] = ctrl_q[`PEFS_PIN3_SEL_BIT];
  assign pin_sel[2] = ctrl_q[`PEFS_PIN2_SEL_BIT];
  assign pin_sel[1] = ctrl_q[`PEFS_PIN1_SEL_BIT];
  assign pin_sel[0] = ctrl_q[`PEFS_PIN0_SEL_BIT];

  // host outputs placed on their pins, input pins carry zero
  // an unselected host output is simply not looked at
  assign hif_out = {3'b000, host_interrupt_out, 1'b0,
                    host_dma_request_out, host_ready_out, 1'b0};

  // ----------------------------------------------------------------
  // pin cells
  // ----------------------------------------------------------------
  // each cell registers its outputs, so a select change reaches
  // the pads one cycle after the control word moves
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      // direction of the host function fixed per pin
      pefs_pin_cell #(
        .HIF_IS_OUT ((`PEFS_HIF_OUT_PINS >> gi) & 1)
      ) u_cell (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .sel_host  (pin_sel[gi]),
        .pad_in    (pad_in[gi]),
        .pad_out_q (pad_out[gi]),
        .pad_oe_q  (pad_oe[gi]),
        .gp_out    (gp_out[gi]),
        .gp_oe     (gp_oe[gi]),
        .gp_in_q   (gp_in[gi]),
        .hif_out   (hif_out[gi]),
        .hif_in_q  (hif_in[gi])
      );
    end
  endgenerate

  // host inputs from the registered cell outputs
  assign host_reg_select_in   = hif_in[7];
  assign host_write_strobe_in = hif_in[6];
  assign host_read_strobe_in  = hif_in[5];
  assign host_mode_in         = hif_in[3];
  assign host_enable_in       = hif_in[0];

endmodule

/* File: pefs_top_properties.sv */
/*
  checker of pin routing and read data for the pin select block.
  assumes it is bound to pefs_top: one clock, sync active-low reset.
*/
`timescale 1ns/10ps

module pefs_props (
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // pads and general port
  input wire [7:0]  pad_in,
  input wire [7:0]  pad_out,
  input wire [7:0]  pad_oe,
  input wire [7:0]  gp_oe,
  input wire [7:0]  gp_in,
  // host side
  input wire        host_reg_select_in,
  input wire        host_write_strobe_in,
  input wire        host_read_strobe_in,
  input wire        host_mode_in,
  input wire        host_enable_in,
  input wire        host_interrupt_out,
  input wire        host_dma_request_out,
  input wire        host_ready_out,
  // read data
  input wire        s_axi_rvalid,
  input wire [31:0] s_axi_rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------
  // host inputs copy their own pad a cycle later, port side silent
  // ----------------------------------------------------------------
  property p_pin7; host_reg_select_in |-> $past(pad_in[7]) && !gp_in[7]; endproperty
  a_pin7: assert property (p_pin7) else $error("pin7 host input wrong");
  property p_pin6; host_write_strobe_in |-> $past(pad_in[6]) && !gp_in[6]; endproperty
  a_pin6: assert property (p_pin6) else $error("pin6 host input wrong");
  property p_pin5; host_read_strobe_in |-> $past(pad_in[5]) && !gp_in[5]; endproperty
  a_pin5: assert property (p_pin5) else $error("pin5 host input wrong");
  property p_pin3; host_mode_in |-> $past(pad_in[3]) && !gp_in[3]; endproperty
  a_pin3: assert property (p_pin3) else $error("pin3 host input wrong");
  property p_pin0; host_enable_in |-> $past(pad_in[0]) && !gp_in[0]; endproperty
  a_pin0: assert property (p_pin0) else $error("pin0 host input wrong");
  // ----------------------------------------------------------------
  // pad driven without port enable carries the host output
  // ----------------------------------------------------------------
  property p_pin4; pad_oe[4] && !$past(gp_oe[4]) |-> pad_out[4] == $past(host_interrupt_out);
  endproperty
  a_pin4: assert property (p_pin4) else $error("pin4 host output wrong");
  property p_pin2; pad_oe[2] && !$past(gp_oe[2]) |-> pad_out[2] == $past(host_dma_request_out);
  endproperty
  a_pin2: assert property (p_pin2) else $error("pin2 host output wrong");
  property p_pin1; pad_oe[1] && !$past(gp_oe[1]) |-> pad_out[1] == $past(host_ready_out);
  endproperty
  a_pin1: assert property (p_pin1) else $error("pin1 host output wrong");
  // reserved and upper bits never read back set
  property p_rsvd; s_axi_rvalid |-> (s_axi_rdata & 32'hffffaaaa) == 32'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read set");
endmodule

bind pefs_top pefs_props u_props (.aclk, .aresetn, .pad_in, .pad_out, .pad_oe, .gp_oe, .gp_in,
  .host_reg_select_in, .host_write_strobe_in, .host_read_strobe_in, .host_mode_in,
  .host_enable_in, .host_interrupt_out, .host_dma_request_out, .host_ready_out,
  .s_axi_rvalid, .s_axi_rdata);

/* File: pefs_top_tb.sv */
/*
  self-checking bench of the pin select block: axi4-lite master,
  random pad traffic, queued expectations checked by monitors.
  assumes pefs_top and pefs_defs.vh on the compile path.
*/
`timescale 1ns/10ps
`include "pefs_defs.vh"

module pefs_top_tb;
  logic        aclk = 0;
  logic        aresetn, boot, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic [7:0]  pin, go, ge;
  logic [2:0]  ho;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [7:0]  pout, poe, gi;
  wire  [4:0]  hi;
  logic [15:0] lf = 16'd9100;
  logic [15:0] cm;                // mirror of the control register
  logic [34:0] bq[$], e;
  logic [57:0] pq[$], p;
  int          bad_count, tests_run, n;

  always #2 aclk = ~aclk;

  pefs_top u_dut (.aclk(aclk), .aresetn(aresetn), .hif_boot_mode(boot),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pad_in(pin), .pad_out(pout), .pad_oe(poe), .gp_out(go), .gp_oe(ge), .gp_in(gi),
    .host_reg_select_in(hi[4]), .host_write_strobe_in(hi[3]), .host_read_strobe_in(hi[2]),
    .host_mode_in(hi[1]), .host_enable_in(hi[0]), .host_interrupt_out(ho[2]),
    .host_dma_request_out(ho[1]), .host_ready_out(ho[0]));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [15:0] nx(input [15:0] v);
    nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // expected {mask, pad_out, pad_oe, gp_in, host inputs}
  function [57:0] pexp(input [7:0] s, pi, o, oe, input [2:0] h);
    logic [7:0] po, pe, g, q, m, hv;
    integer i;
    po = 0; pe = 0; g = 0; q = 0; m = 0;
    hv = {3'h0, h[2], 1'b0, h[1], h[0], 1'b0};
    for (i = 0; i < 8; i++) begin
      if (!s[i]) begin
        po[i] = o[i]; pe[i] = oe[i]; g[i] = pi[i]; m[i] = 1;
      end else if (`PEFS_HIF_OUT_PINS >> i & 1) begin
        po[i] = hv[i]; pe[i] = 1; m[i] = 1;
      end else begin
        q[i] = pi[i];
      end
    end
    pexp = {m, 21'h1fffff, po, pe, g, q[7], q[6], q[5], q[3], q[0]};
  endfunction

  task chk(input string nm, input [63:0] s, x);
    tests_run++;
    if (s !== x) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask

  task test_done;
    if (bad_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one axi4-lite write or read, expectation queued first
  task bus(input w, input [11:0] a, input [31:0] d, input [3:0] s, input [33:0] x);
    int k;
    @(posedge aclk);
    bq.push_back({w, x});
    if (w) begin
      awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1; wvalid <= 1; bready <= 1;
    end else begin
      araddr <= a; arvalid <= 1; rready <= 1;
    end
    for (k = 0; k < 40 && !(bvalid && bready || rvalid && rready); k++) begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (arready) arvalid <= 0;
    end
    bready <= 0;
    rready <= 0;
    if (k == 40) begin
      bad_count++;
      test_done;
    end
  endtask

  // random pad and port traffic against the mirrored selection
  task pins(input int t);
    repeat (t) begin
      @(posedge aclk);
      lf = nx(lf); pin <= lf[7:0]; go <= lf[15:8];
      lf = nx(lf); ge <= lf[7:0]; ho <= lf[10:8];
      @(posedge aclk);
      pq.push_back(pexp({cm[14], cm[12], cm[10], cm[8], cm[6], cm[4], cm[2], cm[0]},
                        pin, go, ge, ho));
    end
  endtask

  task rst(input b);
    aresetn <= 0;
    boot    <= b;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    cm = b ? 16'h5555 : 16'h0040;
  endtask

  // ----------------------------------------------------------------
  // monitors
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (bvalid && bready || rvalid && rready) begin
      e = bq.pop_front();
      if (e[34]) chk("bresp", bresp, e[33:32]);
      else chk("read", {rresp, rdata}, e[33:0]);
    end
  end

  always @(negedge aclk) begin
    if (pq.size() > 0) begin
      p = pq.pop_front();
      chk("pins", {pout, poe, gi, hi} & p[57:29], p[28:0]);
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} <= 0;
    {awaddr, araddr, wdata, wstrb} <= 0;
    {pin, go, ge, ho} <= 0;
    rst(0);
    bus(0, 0, 0, 0, {18'h0, cm});
    pins(6);
    for (n = 0; n < 4; n++) begin
      lf = nx(lf);
      wdata <= 0;
      bus(1, 12'h002, {lf, lf & 16'h5555}, 4'h3, 0);
      cm = lf & 16'h5555;
      bus(0, 0, 0, 0, {18'h0, cm});
      pins(4);
    end
    bus(1, 0, 32'hffff0000, 4'hf, 0);
    cm = 0;
    bus(1, 0, 32'h5555, 4'h1, 0);
    cm = 16'h0055;
    bus(0, 12'h003, 0, 0, {18'h0, cm});
    bus(1, 0, 32'h1400, 4'h2, 0);
    cm = 16'h1455;
    bus(0, 0, 0, 0, {18'h0, cm});
    for (n = 0; n < 8; n++) begin
      bus(1, 0, 32'h1 << 2 * n, 4'hf, 0);
      cm = 16'h1 << 2 * n;
      pins(3);
    end
    bus(1, 12'h004, 32'h5555, 4'hf, {`PEFS_RESP_SLVERR, 32'h0});
    bus(0, 12'h004, 0, 0, {`PEFS_RESP_SLVERR, 32'h0});
    bus(0, 0, 0, 0, {18'h0, cm});
    rst(1);
    bus(0, 0, 0, 0, {18'h0, cm});
    pins(6);
    test_done;
  end
endmodule
